// file: bench/e1_alarm_code_interrupt_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module e1_alarm_code_interrupt_unit_bench
  import e1aci_pkg::*;
;
  // -----------------------------------------------------------
  // Signals and instances
  // -----------------------------------------------------------
  localparam logic [31:0] ALL = '1;
  localparam logic [7:0] CAT [11] = '{8'h20, 8'h02, 8'h02, 8'h01,
    8'h08, 8'h08, 8'h04, 8'h80, 8'h80, 8'h80, 8'h80};
  logic mclk, rst_n, hwrite, hreadyout, hresp, rx_bit_en, rx_bit;
  logic rx_slot_stb, nfas_stb, mfas_stb, tx_slot_stb, tx_insert;
  logic frame_sync_lost, sig_multiframe_unaligned, irq_pin;
  logic tx_remote_alarm, tx_y_alarm, irq_o, irq_oe_n;
  logic [7:0] haddr, rx_slot_data, nfas_word, mfas_word, tx_code;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, q;
  logic [4:0] rx_slot, tx_slot;
  logic [5:0] cnt_lsb, cnt_full;
  e1aci_evt_s evt;
  int error_cnt, n_checks;

  // Free-running 10 MHz clock.
  always #50 mclk = ~mclk;

  // The bus is the only master, so hready loops back from the slave.
  e1aci_top u_dut (.mclk, .rst_n, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .rx_bit_en, .rx_bit, .rx_slot_stb, .rx_slot,
    .rx_slot_data, .nfas_stb, .nfas_word, .mfas_stb, .mfas_word,
    .frame_sync_lost, .sig_multiframe_unaligned, .evt, .cnt_lsb,
    .cnt_full, .tx_slot_stb, .tx_slot, .tx_insert, .tx_code,
    .tx_remote_alarm, .tx_y_alarm, .irq_o, .irq_oe_n);
  e1aci_host u_host (.irq_o, .irq_oe_n, .irq_pin);

  // -----------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t word %0h exp %0h", $time, g, e);
    end
  endtask

  task automatic chkp(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t pin %b exp %b", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Waits for hready; a slave that never answers ends the run.
  task automatic rdy;
    int k = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        error_cnt++;
        wrap_up();
      end
      @(posedge mclk);
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic [5:0] i, input logic w,
                     input logic [31:0] d);
    haddr <= {i, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    bus(i, 1'b1, d);
  endtask

  task automatic rdm(input logic [5:0] i, input logic [31:0] m, e);
    bus(i, 1'b0, 32'h0);
    chk(q & m, e);
  endtask

  task automatic pulse(input e1aci_evt_s e);
    evt <= e;
    tick(1);
    evt <= '0;
    tick(1);
  endtask

  // Sends n line bits, constant or alternating from v.
  task automatic bits(input int n, input logic v, input logic alt);
    for (int k = 0; k < n; k++)
    begin
      rx_bit_en <= 1'b1;
      rx_bit <= alt ? (k[0] ^ v) : v;
      tick(1);
    end
    rx_bit_en <= 1'b0;
    tick(3);
  endtask

  task automatic rxs(input logic [4:0] s, input logic [7:0] d);
    rx_slot <= s;
    rx_slot_data <= d;
    rx_slot_stb <= 1'b1;
    tick(1);
    rx_slot_stb <= 1'b0;
    tick(2);
  endtask

  task automatic txs(input logic [4:0] s);
    tx_slot <= s;
    tx_slot_stb <= 1'b1;
    tick(1);
    tx_slot_stb <= 1'b0;
    tick(2);
  endtask

  task automatic nm(input logic [7:0] n, input logic [7:0] m);
    nfas_word <= n;
    mfas_word <= m;
    {nfas_stb, mfas_stb} <= 2'b11;
    tick(1);
    {nfas_stb, mfas_stb} <= 2'b00;
    tick(2);
  endtask

  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
      rdm(6'(IDX_MSK0 + i), ALL, i == 0 ? MSK0_RST : MSKN_RST);
    rdm(IDX_VEC, ALL, 32'h0);
    chkp(irq_pin, 1'b1);
    chkp(hresp, 1'b0);
    pulse(e1aci_evt_s'(11'h002));
    chkp(irq_pin, 1'b1);
    rdm(6'h10, ALL, 32'h0);
  endtask

  // Each of the 11 evt pulses alone, then two categories pending at once.
  task automatic t_cat;
    for (int i = 0; i < 4; i++)
      wr(6'(IDX_MSK0 + i), 32'h0);
    for (int b = 0; b < 11; b++)
    begin
      pulse(e1aci_evt_s'(11'h001 << b));
      chkp(irq_pin, 1'b0);
      rdm(IDX_VEC, ALL, {24'h0, CAT[b]});
      chkp(irq_pin, 1'b1);
    end
    pulse(e1aci_evt_s'(11'h040));
    pulse(e1aci_evt_s'(11'h008));
    chkp(irq_pin, 1'b0);
    rdm(IDX_VEC, ALL, 32'h05);
    wr(IDX_CTRL, 32'h04);
    pulse(e1aci_evt_s'(11'h040));
    chkp(irq_pin, 1'b1);
    rdm(IDX_VEC, ALL, 32'h0);
    wr(IDX_CTRL, 32'h0);
    rdm(IDX_MSK0, ALL, 32'h0);
  endtask

  task automatic t_code;
    wr(IDX_CIW, 32'hA5);
    wr(IDX_TXSEL, 32'h80000020);
    txs(5'd5);
    chkp(tx_insert, 1'b1);
    chk({24'h0, tx_code}, 32'hA5);
    txs(5'd6);
    chkp(tx_insert, 1'b0);
    txs(5'd31);
    chkp(tx_insert, 1'b1);
    wr(IDX_CDW, 32'h3C);
    wr(IDX_DWM, 32'hF0);
    wr(IDX_RXSEL, 32'h80);
    rxs(5'd7, 8'h35);
    rdm(IDX_VEC, ALL, 32'h02);
    rxs(5'd7, 8'h4C);
    rdm(IDX_VEC, ALL, 32'h0);
    rxs(5'd8, 8'h3C);
    rdm(IDX_VEC, ALL, 32'h0);
  endtask

  task automatic t_auto;
    frame_sync_lost <= 1'b1;
    sig_multiframe_unaligned <= 1'b1;
    tick(3);
    chkp(tx_remote_alarm, 1'b1);
    chkp(tx_y_alarm, 1'b1);
    wr(IDX_CTRL, 32'h03);
    tick(2);
    chkp(tx_remote_alarm, 1'b0);
    chkp(tx_y_alarm, 1'b0);
    wr(IDX_CTRL, 32'h0);
    frame_sync_lost <= 1'b0;
    tick(3);
    chkp(tx_remote_alarm, 1'b0);
    chkp(tx_y_alarm, 1'b1);
    sig_multiframe_unaligned <= 1'b0;
    tick(3);
    chkp(tx_y_alarm, 1'b0);
  endtask

  // Count boundaries: one bit short, then exactly the figure.
  task automatic t_line;
    bits(254, 1'b0, 1'b0);
    rdm(IDX_STAT, 32'h08, 32'h0);
    bits(1, 1'b0, 1'b0);
    rdm(IDX_STAT, 32'h08, 32'h08);
    rdm(IDX_VEC, ALL, 32'h40);
    bits(31, 1'b1, 1'b0);
    bits(224, 1'b0, 1'b0);
    rdm(IDX_STAT, 32'h08, 32'h08);
    bits(32, 1'b1, 1'b0);
    bits(223, 1'b0, 1'b0);
    rdm(IDX_STAT, 32'h08, 32'h0);
    bits(511, 1'b1, 1'b0);
    rdm(IDX_STAT, 32'h01, 32'h0);
    bits(1, 1'b1, 1'b0);
    rdm(IDX_STAT, 32'h01, 32'h01);
    rdm(IDX_VEC, ALL, 32'h40);
    wr(IDX_CTRL, 32'h08);
    bits(1, 1'b0, 1'b0);
    bits(1023, 1'b1, 1'b0);
    rdm(IDX_STAT, 32'h01, 32'h0);
    bits(1, 1'b1, 1'b0);
    rdm(IDX_STAT, 32'h01, 32'h01);
    wr(IDX_CTRL, 32'h0);
    bits(2, 1'b1, 1'b0);
    bits(510, 1'b0, 1'b1);
    rdm(IDX_STAT, 32'h04, 32'h0);
    bits(1, 1'b0, 1'b0);
    rdm(IDX_STAT, 32'h04, 32'h04);
    rxs(5'd16, 8'hFF);
    rdm(IDX_STAT, 32'h02, 32'h02);
    rxs(5'd16, 8'hFE);
    rdm(IDX_STAT, 32'h02, 32'h0);
    nm(8'h08, 8'h40);
    rdm(IDX_STAT, 32'h30, 32'h30);
    nm(8'hF7, 8'hBF);
    rdm(IDX_STAT, 32'h30, 32'h0);
  endtask

  // Toggle of the first counter, then its wrap from all ones.
  task automatic t_cnt;
    bus(IDX_VEC, 1'b0, 32'h0);
    cnt_lsb <= 6'h01;
    tick(2);
    rdm(IDX_VEC, ALL, 32'h20);
    cnt_full <= 6'h01;
    tick(1);
    cnt_lsb <= 6'h00;
    cnt_full <= 6'h00;
    tick(2);
    rdm(IDX_VEC, ALL, 32'h30);
  endtask

  task automatic t_soft;
    wr(IDX_MSK0, 32'hFF);
    wr(IDX_CTRL, 32'h10);
    wr(IDX_CTRL, 32'h0);
    rdm(IDX_MSK0, ALL, 32'h0);
    rdm(IDX_MSK3, ALL, 32'hFF);
  endtask

  // Inputs settle at time zero; reset is held for 16 cycles.
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {hwrite, rx_bit_en, rx_bit, rx_slot_stb, nfas_stb, mfas_stb} = '0;
    {frame_sync_lost, sig_multiframe_unaligned, tx_slot_stb} = '0;
    {haddr, rx_slot_data, nfas_word, mfas_word, htrans, hwdata} = '0;
    {rx_slot, tx_slot, cnt_lsb, cnt_full, evt} = '0;
    error_cnt = 0;
    n_checks = 0;
    tick(16);
    rst_n <= 1'b1;
    t_reset();
    t_cat();
    t_code();
    t_auto();
    t_line();
    t_cnt();
    t_soft();
    wrap_up();
  end
endmodule
`default_nettype wire

// file: bench/e1aci_host.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// Host side of the open-drain request line.
// -------------------------------------------------------------
module e1aci_host
(
  input wire logic irq_o, // Device pin level.
  input wire logic irq_oe_n, // Device drive, low while driven.
  output logic irq_pin // Line level as the host sees it.
);
  // A released line floats to the pull-up, so the host never sees
  // a stale low after the clearing read.
  assign irq_pin = irq_oe_n ? 1'b1 : irq_o;
endmodule
`default_nettype wire

// file: design/e1aci_top.sv
`timescale 1ns/1ps
`default_nettype none
module e1aci_top
  import e1aci_pkg::*;
(
  input wire logic mclk, // 10 MHz clock.
  input wire logic rst_n, // Asynchronous reset.
  input wire logic hsel, // Slave select.
  input wire logic [7:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire logic rx_bit_en, // One pulse per received bit.
  input wire logic rx_bit, // Received bit, one is a pulse.
  input wire logic rx_slot_stb, // Receive slot byte valid.
  input wire logic [4:0] rx_slot, // Receive slot number.
  input wire logic [7:0] rx_slot_data, // Receive slot byte.
  input wire logic nfas_stb, // Non-frame alignment word valid.
  input wire logic [7:0] nfas_word, // Non-frame alignment word.
  input wire logic mfas_stb, // Multiframe alignment word valid.
  input wire logic [7:0] mfas_word, // Multiframe alignment word.
  input wire logic frame_sync_lost, // Basic frame alignment lost.
  input wire logic sig_multiframe_unaligned, // Multiframe not aligned.
  input wire e1aci_evt_s evt, // Event pulses.
  input wire logic [5:0] cnt_lsb, // Counter least significant bits.
  input wire logic [5:0] cnt_full, // Counter is all ones.
  input wire logic tx_slot_stb, // Transmit slot about to go out.
  input wire logic [4:0] tx_slot, // Transmit slot number.
  output logic tx_insert, // Replace slot with code word.
  output logic [7:0] tx_code, // Code to send.
  output logic tx_remote_alarm, // Send remote alarm bit.
  output logic tx_y_alarm, // Send multiframe Y alarm.
  output logic irq_o, // Request pin level, always low.
  output logic irq_oe_n // Request pin drive, low while driven.
);
  // ----------------------------------------------------------------
  // Bus slave.
  // ----------------------------------------------------------------
  logic [7:0] ciw_q, cdw_q, dwm_q, vec_q, vec_d;
  logic [3:0] ctrl_q;
  logic [31:0] msk_q, txsel_q, rxsel_q, rdata;
  logic wr_q;
  logic [5:0] widx_q;
  logic [5:0] aidx;
  logic acc, rd_vec, soft_rst;
  logic ais_q, ais16_q, aux_q, los_q, rai_q, ymf_q;

  assign aidx = haddr[7:2];
  assign acc = hsel && hready && htrans[1];
  assign rd_vec = acc && !hwrite && aidx == IDX_VEC;
  assign soft_rst = wr_q && widx_q == IDX_CTRL && hwdata[CTL_RST];

  // Read data is formed in the address phase and registered.
  always_comb
  begin
    rdata = 32'h0;
    if (aidx == IDX_VEC) rdata[7:0] = vec_q;
    else if (aidx == IDX_CIW) rdata[7:0] = ciw_q;
    else if (aidx == IDX_CDW) rdata[7:0] = cdw_q;
    else if (aidx == IDX_DWM) rdata[7:0] = dwm_q;
    else if (aidx == IDX_CTRL) rdata[3:0] = ctrl_q;
    else if (aidx == IDX_MSK0) rdata[7:0] = msk_q[7:0];
    else if (aidx == IDX_MSK1) rdata[7:0] = msk_q[15:8];
    else if (aidx == IDX_MSK2) rdata[7:0] = msk_q[23:16] | MSK2_FIXED;
    else if (aidx == IDX_MSK3) rdata[7:0] = msk_q[31:24];
    else if (aidx == IDX_TXSEL) rdata = txsel_q;
    else if (aidx == IDX_RXSEL) rdata = rxsel_q;
    else if (aidx == IDX_STAT)
      rdata[5:0] = {ymf_q, rai_q, los_q, aux_q, ais16_q, ais_q};
  end

  // Zero wait states: every transfer completes in its first data cycle.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_q <= 1'b0;
      widx_q <= 6'h0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_q <= acc && hwrite;
      if (acc)
        widx_q <= aidx;
      if (acc && !hwrite)
        hrdata <= rdata;
    end
  end

  // Plain configuration words.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ciw_q <= 8'h0;
      cdw_q <= 8'h0;
      dwm_q <= 8'h0;
      txsel_q <= 32'h0;
      rxsel_q <= 32'h0;
      ctrl_q <= CTRL_RST;
    end
    else if (wr_q)
    begin
      if (widx_q == IDX_CIW) ciw_q <= hwdata[7:0];
      else if (widx_q == IDX_CDW) cdw_q <= hwdata[7:0];
      else if (widx_q == IDX_DWM) dwm_q <= hwdata[7:0];
      else if (widx_q == IDX_TXSEL) txsel_q <= hwdata;
      else if (widx_q == IDX_RXSEL) rxsel_q <= hwdata;
      else if (widx_q == IDX_CTRL) ctrl_q <= hwdata[3:0];
    end
  end

  // Masks: a one masks. The soft reset bit restores them like the pin.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      msk_q <= {MSKN_RST, MSKN_RST, MSKN_RST, MSK0_RST};
    else if (soft_rst)
      msk_q <= {MSKN_RST, MSKN_RST, MSKN_RST, MSK0_RST};
    else if (wr_q)
    begin
      if (widx_q == IDX_MSK0) msk_q[7:0] <= hwdata[7:0];
      else if (widx_q == IDX_MSK1) msk_q[15:8] <= hwdata[7:0];
      else if (widx_q == IDX_MSK2) msk_q[23:16] <= hwdata[7:0];
      else if (widx_q == IDX_MSK3) msk_q[31:24] <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Code insertion and detection.
  // ----------------------------------------------------------------
  logic data_match;
  assign data_match = rx_slot_stb && rxsel_q[rx_slot]
    && ((rx_slot_data ^ cdw_q) & dwm_q) == 8'h0;

  // Insertion is decided per slot and held until the next slot strobe.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_insert <= 1'b0;
      tx_code <= 8'h0;
      tx_remote_alarm <= 1'b0;
      tx_y_alarm <= 1'b0;
    end
    else
    begin
      if (tx_slot_stb)
      begin
        tx_insert <= txsel_q[tx_slot];
        tx_code <= ciw_q;
      end
      tx_remote_alarm <= !ctrl_q[CTL_RAI_MAN] && frame_sync_lost;
      tx_y_alarm <= !ctrl_q[CTL_Y_MAN] && sig_multiframe_unaligned;
    end
  end

  // ----------------------------------------------------------------
  // Receive alarms.
  // ----------------------------------------------------------------
  logic [10:0] ones_q;
  logic [9:0] alt_q;
  logic prev_q, win_q;
  logic [7:0] zcnt_q, wones_q;
  logic [10:0] ais_lim;
  assign ais_lim = ctrl_q[CTL_AIS2] ? AIS_LONG : AIS_SHORT;

  // All-ones runs saturate at AIS_LONG in both modes; alternating pattern runs saturate at AUX_BITS.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ones_q <= 11'h0;
      alt_q <= 10'h0;
      prev_q <= 1'b0;
      ais_q <= 1'b0;
      aux_q <= 1'b0;
    end
    else if (rx_bit_en)
    begin
      prev_q <= rx_bit;
      if (!rx_bit) ones_q <= 11'h0;
      else if (ones_q != AIS_LONG) ones_q <= ones_q + 11'h1;
      if (rx_bit == prev_q) alt_q <= 10'h1;
      else if (alt_q != AUX_BITS) alt_q <= alt_q + 10'h1;
      ais_q <= rx_bit && ones_q + 11'h1 >= ais_lim;
      aux_q <= rx_bit != prev_q && alt_q + 10'h1 >= AUX_BITS;
    end
  end

  // Loss of signal: a zero run sets it; a qualifying window clears it.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      los_q <= 1'b0;
      win_q <= 1'b0;
      zcnt_q <= 8'h0;
      wones_q <= 8'h0;
    end
    else if (rx_bit_en)
    begin
      if (!los_q)
      begin
        zcnt_q <= rx_bit ? 8'h0 : zcnt_q + 8'h1;
        if (!rx_bit && zcnt_q == LOS_RUN - 8'h1)
          los_q <= 1'b1;
      end
      else if (!win_q)
      begin
        win_q <= rx_bit;
        zcnt_q <= 8'h1;
        wones_q <= 8'h1;
      end
      else
      begin
        zcnt_q <= zcnt_q + 8'h1;
        wones_q <= wones_q + {7'h0, rx_bit};
        if (zcnt_q == LOS_RUN - 8'h1)
        begin
          win_q <= 1'b0;
          zcnt_q <= 8'h0;
          if (wones_q + {7'h0, rx_bit} >= LOS_ONES)
            los_q <= 1'b0;
        end
      end
    end
  end

  // Overhead bits and slot 16 are latched from their strobes.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rai_q <= 1'b0;
      ymf_q <= 1'b0;
      ais16_q <= 1'b0;
    end
    else
    begin
      if (nfas_stb) rai_q <= nfas_word[NFAS_RAI_BIT];
      if (mfas_stb) ymf_q <= mfas_word[MFAS_Y_BIT];
      if (rx_slot_stb && rx_slot == SLOT16)
        ais16_q <= rx_slot_data == 8'hFF;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events and vector.
  // ----------------------------------------------------------------
  logic [5:0] ast_q, lsb_q, full_q, tog, wrap;
  logic prime_q;
  logic [5:0] ast_now;
  logic [31:0] ev, pend;
  logic [7:0] cat;
  assign ast_now = {ymf_q, aux_q, los_q, ais16_q, ais_q, rai_q};
  assign tog = prime_q ? (cnt_lsb ^ lsb_q) : 6'h0;
  assign wrap = tog & full_q;

  // Edge memories; the prime flag hides the first sample after reset.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ast_q <= 6'h0;
      lsb_q <= 6'h0;
      full_q <= 6'h0;
      prime_q <= 1'b0;
    end
    else
    begin
      ast_q <= ast_now;
      lsb_q <= cnt_lsb;
      full_q <= cnt_full;
      prime_q <= 1'b1;
    end
  end

  assign ev = {
    evt.mf_loss, evt.crc_sync_loss, evt.remote_crc_fail,
    ast_now[5] & ~ast_q[5], evt.one_sec, evt.buf_stop, evt.buf_start,
    data_match,
    wrap[C_EB], wrap[C_CRC], evt.crc_mf_align, wrap[C_FAS], wrap[C_RCR],
    wrap[C_BER], ast_now[4] & ~ast_q[4], 1'b0,
    tog[C_EB], tog[C_CRC], evt.consec_fas_err, tog[C_BPV], tog[C_RCR],
    tog[C_BER], evt.sig_change, 1'b0,
    evt.frame_loss, ast_now[0] & ~ast_q[0], ast_now[1] & ~ast_q[1],
    ast_now[2] & ~ast_q[2], ast_now[3] & ~ast_q[3], tog[C_FAS],
    wrap[C_BPV], evt.slip};
  assign pend = ctrl_q[CTL_HOLD] ? 32'h0 : ev & ~msk_q;

  // Fold each pending event into its category bit.
  always_comb
  begin
    cat = 8'h0;
    for (int i = 0; i < 32; i++)
      if (pend[i]) cat[EVT_CAT[i]] = 1'b1;
  end

  // A new event in the clearing cycle survives the clear.
  assign vec_d = (rd_vec || soft_rst ? 8'h0 : vec_q) | cat;

  // The request pin follows the vector; its drive is a flop.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vec_q <= 8'h0;
      irq_oe_n <= 1'b1;
      irq_o <= 1'b0;
    end
    else
    begin
      vec_q <= vec_d;
      irq_oe_n <= ~|vec_d;
      irq_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  sequence vec_read_s;
    rd_vec && cat == 8'h0;
  endsequence
  sequence vec_quiet_s;
    vec_q == 8'h0 && irq_oe_n;
  endsequence
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  vec_clear_a: assert property (vec_read_s |=> vec_quiet_s)
    else $error("vector not cleared by read");
  irq_follows_a: assert property (irq_oe_n == (vec_q == 8'h0))
    else $error("request line disagrees with vector");
  event_sets_a: assert property (pend[24] |=> vec_q[1] && !irq_oe_n)
    else $error("data match did not set maintenance bit");
  suspend_a: assert property (ctrl_q[CTL_HOLD] && !rd_vec
    && !soft_rst |=> vec_q == $past(vec_q))
    else $error("event passed while suspended");
  insert_a: assert property (tx_slot_stb && txsel_q[tx_slot] |=>
    tx_insert && tx_code == $past(ciw_q))
    else $error("code not inserted");
  los_set_a: assert property ($rose(los_q) |->
    $past(zcnt_q) == 8'hFE && !$past(rx_bit))
    else $error("loss declared early");
  rai_auto_a: assert property (!ctrl_q[CTL_RAI_MAN] && frame_sync_lost
    ##1 !ctrl_q[CTL_RAI_MAN] |-> tx_remote_alarm)
    else $error("remote alarm not sent");
  y_auto_a: assert property (ctrl_q[CTL_Y_MAN] |=> !tx_y_alarm)
    else $error("Y alarm sent while disabled");
  mask_rst_a: assert property (soft_rst |=>
    msk_q == {MSKN_RST, MSKN_RST, MSKN_RST, MSK0_RST})
    else $error("soft reset left masks");
endmodule
`default_nettype wire

// file: include/e1aci_pkg.sv
package e1aci_pkg;
  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_VEC = 6'h12;
  localparam logic [5:0] IDX_CIW = 6'h17;
  localparam logic [5:0] IDX_CDW = 6'h18;
  localparam logic [5:0] IDX_DWM = 6'h19;
  localparam logic [5:0] IDX_CTRL = 6'h1A;
  localparam logic [5:0] IDX_MSK0 = 6'h1B;
  localparam logic [5:0] IDX_MSK1 = 6'h1C;
  localparam logic [5:0] IDX_MSK2 = 6'h1D;
  localparam logic [5:0] IDX_MSK3 = 6'h1E;
  localparam logic [5:0] IDX_TXSEL = 6'h20;
  localparam logic [5:0] IDX_RXSEL = 6'h21;
  localparam logic [5:0] IDX_STAT = 6'h22;
  // ----------------------------------------------------------------
  // Control bit positions and reset values.
  // ----------------------------------------------------------------
  localparam int CTL_RAI_MAN = 0;
  localparam int CTL_Y_MAN = 1;
  localparam int CTL_HOLD = 2;
  localparam int CTL_AIS2 = 3;
  localparam int CTL_RST = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] MSK0_RST = 8'h00;
  localparam logic [7:0] MSKN_RST = 8'hFF;
  localparam logic [7:0] MSK2_FIXED = 8'h01;
  // ----------------------------------------------------------------
  // Alarm bit counts and slot numbers.
  // ----------------------------------------------------------------
  localparam logic [10:0] AIS_SHORT = 11'h200;
  localparam logic [10:0] AIS_LONG = 11'h400;
  localparam logic [9:0] AUX_BITS = 10'h200;
  localparam logic [7:0] LOS_RUN = 8'hFF;
  localparam logic [7:0] LOS_ONES = 8'h20;
  localparam logic [4:0] SLOT16 = 5'h10;
  localparam int NFAS_RAI_BIT = 3;
  localparam int MFAS_Y_BIT = 6;
  // ----------------------------------------------------------------
  // Vector categories, least to most significant.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CAT_SIG = 3'h0, CAT_MNT = 3'h1, CAT_SLIP = 3'h2, CAT_SEC = 3'h3,
    CAT_OVF = 3'h4, CAT_CNT = 3'h5, CAT_ALARM = 3'h6, CAT_SYNC = 3'h7
  } e1aci_cat_e;
  // Category of each mask bit, index 8*word + bit.
  localparam e1aci_cat_e EVT_CAT [32] = '{
    CAT_SLIP, CAT_OVF, CAT_CNT, CAT_ALARM, CAT_ALARM, CAT_ALARM, CAT_ALARM,
    CAT_SYNC,
    CAT_SIG, CAT_SIG, CAT_CNT, CAT_CNT, CAT_CNT, CAT_CNT, CAT_CNT, CAT_CNT,
    CAT_SIG, CAT_ALARM, CAT_OVF, CAT_OVF, CAT_OVF, CAT_SEC, CAT_OVF, CAT_OVF,
    CAT_MNT, CAT_MNT, CAT_MNT, CAT_SEC, CAT_SYNC, CAT_SYNC, CAT_SYNC, CAT_SYNC};
  // Counter order in the lsb and all-ones vectors.
  localparam int C_EB = 0;
  localparam int C_CRC = 1;
  localparam int C_FAS = 2;
  localparam int C_BPV = 3;
  localparam int C_RCR = 4;
  localparam int C_BER = 5;
  // One-cycle event pulses from the rest of the framer.
  typedef struct packed {
    logic frame_loss;
    logic mf_loss;
    logic crc_sync_loss;
    logic remote_crc_fail;
    logic slip;
    logic one_sec;
    logic crc_mf_align;
    logic sig_change;
    logic buf_stop;
    logic buf_start;
    logic consec_fas_err;
  } e1aci_evt_s;
endpackage
